// >>> rtl/keyed_watchdog_timer_defines.svh
`ifndef KEYED_WATCHDOG_TIMER_DEFINES_SVH
`define KEYED_WATCHDOG_TIMER_DEFINES_SVH

// Register byte offsets
`define WDT_OFS_MODE 5'h00
`define WDT_OFS_CONFIG 5'h04
`define WDT_OFS_RESTART 5'h08
`define WDT_OFS_STATUS 5'h0c
`define WDT_OFS_IRQ_STATUS 5'h10
`define WDT_OFS_IRQ_CLEAR 5'h14
`define WDT_OFS_IRQ_ENABLE 5'h18

// Mode register fields
`define WDT_MODE_KEY_MSB 15
`define WDT_MODE_KEY_LSB 4
`define WDT_MODE_KEY 12'h234
`define WDT_MODE_PIN_BIT 3
`define WDT_MODE_IRQ_BIT 2
`define WDT_MODE_RST_BIT 1
`define WDT_MODE_EN_BIT 0

// Tick and preload config fields
`define WDT_CFG_KEY_MSB 15
`define WDT_CFG_KEY_LSB 7
`define WDT_CFG_KEY 9'h06e
`define WDT_CFG_PRE_MSB 5
`define WDT_CFG_PRE_LSB 2
`define WDT_CFG_SEL_MSB 1
`define WDT_CFG_SEL_LSB 0

// Restart key and preload low part
`define WDT_RESTART_KEY 16'hc071
`define WDT_PRELOAD_LOW 12'hfff

// Divider masks for select codes 0..3 (divide by 32, 128, 1024, 4096)
`define WDT_DIV_MASK_0 12'h01f
`define WDT_DIV_MASK_1 12'h07f
`define WDT_DIV_MASK_2 12'h3ff
`define WDT_DIV_MASK_3 12'hfff

// Overflow pin pulse length in master clock cycles
`define WDT_PIN_PULSE_CYCLES 4'h8

// Event bits of the interrupt status register
`define WDT_EVT_OVERFLOW 0
`define WDT_EVT_BADKEY 1

// Reset values
`define WDT_RST_MODE 4'h0
`define WDT_RST_PRE 4'h0
`define WDT_RST_SEL 2'h0
`define WDT_RST_COUNT 16'h0fff

`endif

// >>> rtl/keyed_watchdog_timer_pkg.sv
package keyed_watchdog_timer_pkg;

  // Whole state of the watchdog, registered in one place
  typedef struct packed {
    logic pinEn;
    logic interrupt_on_overflow;
    logic reset_on_overflow;
    logic wdEn;
    logic [3:0] preHigh;
    logic [1:0] divSel;
    logic [15:0] count;
    logic [11:0] prescale;
    logic ovfFlag;
    logic [3:0] pinCnt;
    logic pinN;
    logic irqPulse;
    logic rstPulse;
    logic [1:0] evtStat;
    logic [1:0] evtEn;
    logic irqLevel;
    logic waitReq;
    logic [31:0] rdata;
  } wdt_state_t;

endpackage

// >>> rtl/keyed_watchdog_timer.sv
`timescale 1ns/1ps
`include "keyed_watchdog_timer_defines.svh"
// Contract
// - Overflow with reset enable set raises the internal system reset request.
// - Overflow with interrupt enable set emits one pulse toward the interrupt controller.
// - Overflow with pin enable set drives overflow pin low for 8 clocks.
// - Timing element is a 16-bit down counter stepped by the divided tick.
// - Restart loads low twelve bits ones, bits 15:12 from the preload nibble.
// - Select codes 0..3 give ticks at clock divided by 32, 128, 1024, 4096.
// - Mode and config bits take effect only with the right key in the same write; interrupt enable bits take no key.
// - Mode register accepts writes only with key 0x234; key reads as zero.
// - Config register accepts writes only with key 0x06E; key reads as zero.
// - Master enable clear suppresses all overflow outputs.
// - Writing 0xC071 to restart register reloads counter; other values leave it alone but set the bad-key event.
// - Overflow flag sets on overflow, cleared by restart or reset.
module keyed_watchdog_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Overflow outputs
  output logic overflowInterruptOut,
  output logic sysResetReq,
  output logic overflowPin_n,
  // Event interrupt
  output logic irq
);

  keyed_watchdog_timer_pkg::wdt_state_t stQ;
  keyed_watchdog_timer_pkg::wdt_state_t stD;

  logic tickNow;
  logic ovfEvent;
  logic wrAcc;
  logic lowHalf;
  logic modeWrite;
  logic cfgWrite;
  logic modeKeyOk;
  logic cfgKeyOk;
  logic restartHit;
  logic restartBad;
  logic [1:0] evtSet;
  logic [1:0] evtClr;

  // Tick when the prescaler's low bits for the selected divisor are all ones
  function automatic logic div_tick(input logic [11:0] pre, input logic [1:0] sel);
    logic [11:0] mask;
    mask = `WDT_DIV_MASK_3;
    case (sel)
      2'h0: mask = `WDT_DIV_MASK_0;
      2'h1: mask = `WDT_DIV_MASK_1;
      2'h2: mask = `WDT_DIV_MASK_2;
      default: mask = `WDT_DIV_MASK_3;
    endcase
    return (pre & mask) == mask;
  endfunction

  // Request decode; an access completes at the edge where waitrequest is low
  assign wrAcc = write && !stQ.waitReq;
  assign lowHalf = byteenable[1:0] == 2'h3;
  assign modeWrite = wrAcc && lowHalf && address == `WDT_OFS_MODE;
  assign cfgWrite = wrAcc && lowHalf && address == `WDT_OFS_CONFIG;
  assign modeKeyOk = writedata[`WDT_MODE_KEY_MSB:`WDT_MODE_KEY_LSB] == `WDT_MODE_KEY;
  assign cfgKeyOk = writedata[`WDT_CFG_KEY_MSB:`WDT_CFG_KEY_LSB] == `WDT_CFG_KEY;
  assign restartHit = wrAcc && lowHalf && address == `WDT_OFS_RESTART
    && writedata[15:0] == `WDT_RESTART_KEY;
  assign restartBad = wrAcc && address == `WDT_OFS_RESTART && !restartHit;

  // Tick and overflow detection
  assign tickNow = div_tick(stQ.prescale, stQ.divSel);
  assign ovfEvent = tickNow && stQ.wdEn && stQ.count == 16'h0000;

  // Interrupt events: overflow and any rejected keyed write
  assign evtSet[`WDT_EVT_OVERFLOW] = ovfEvent;
  assign evtSet[`WDT_EVT_BADKEY] = (modeWrite && !modeKeyOk) || (cfgWrite && !cfgKeyOk) || restartBad;
  assign evtClr = (wrAcc && address == `WDT_OFS_IRQ_CLEAR) ? writedata[1:0] : 2'h0;

  // Next-state logic for the whole block
  always_comb begin
    stD = stQ;
    // Bus handshake: one wait cycle, then the access completes
    stD.waitReq = 1'b1;
    if ((read || write) && stQ.waitReq) begin
      stD.waitReq = 1'b0;
    end
    // Read data is captured with the wait cycle so it stands at completion
    if (read && stQ.waitReq) begin
      if (address == `WDT_OFS_MODE) begin
        stD.rdata = {28'h0000000, stQ.pinEn, stQ.interrupt_on_overflow, stQ.reset_on_overflow, stQ.wdEn};
      end else if (address == `WDT_OFS_CONFIG) begin
        stD.rdata = {26'h0000000, stQ.preHigh, stQ.divSel};
      end else if (address == `WDT_OFS_STATUS) begin
        stD.rdata = {31'h00000000, stQ.ovfFlag};
      end else if (address == `WDT_OFS_IRQ_STATUS) begin
        stD.rdata = {30'h00000000, stQ.evtStat};
      end else if (address == `WDT_OFS_IRQ_ENABLE) begin
        stD.rdata = {30'h00000000, stQ.evtEn};
      end else begin
        stD.rdata = 32'h00000000;
      end
    end
    // Keyed control writes; a bad key leaves the register untouched
    if (modeWrite && modeKeyOk) begin
      stD.pinEn = writedata[`WDT_MODE_PIN_BIT];
      stD.interrupt_on_overflow = writedata[`WDT_MODE_IRQ_BIT];
      stD.reset_on_overflow = writedata[`WDT_MODE_RST_BIT];
      stD.wdEn = writedata[`WDT_MODE_EN_BIT];
    end
    if (cfgWrite && cfgKeyOk) begin
      stD.preHigh = writedata[`WDT_CFG_PRE_MSB:`WDT_CFG_PRE_LSB];
      stD.divSel = writedata[`WDT_CFG_SEL_MSB:`WDT_CFG_SEL_LSB];
    end
    if (wrAcc && byteenable[0] && address == `WDT_OFS_IRQ_ENABLE) begin
      stD.evtEn = writedata[1:0];
    end
    // Free-running prescaler shared by all divisor taps
    stD.prescale = stQ.prescale + 12'h001;
    // Down counter; restart has priority over a coincident tick
    if (restartHit) begin
      stD.count = {stQ.preHigh, `WDT_PRELOAD_LOW};
    end else if (tickNow && stQ.wdEn) begin
      stD.count = stQ.count - 16'h0001;
    end
    // Overflow flag: overflow wins over a restart in the same cycle
    if (ovfEvent) begin
      stD.ovfFlag = 1'b1;
    end else if (restartHit) begin
      stD.ovfFlag = 1'b0;
    end
    // Overflow outputs, all gated by the master enable through ovfEvent
    stD.irqPulse = ovfEvent && stQ.interrupt_on_overflow;
    stD.rstPulse = ovfEvent && stQ.reset_on_overflow;
    if (ovfEvent && stQ.pinEn) begin
      stD.pinCnt = `WDT_PIN_PULSE_CYCLES;
    end else if (stQ.pinCnt != 4'h0) begin
      stD.pinCnt = stQ.pinCnt - 4'h1;
    end
    stD.pinN = stD.pinCnt == 4'h0;
    // Sticky events, a set in the clearing cycle survives
    stD.evtStat = (stQ.evtStat & ~evtClr) | evtSet;
    stD.irqLevel = |(stD.evtStat & stD.evtEn);
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stQ <= '{pinEn: 1'b0, interrupt_on_overflow: 1'b0, reset_on_overflow: 1'b0, wdEn: 1'b0,
               preHigh: `WDT_RST_PRE, divSel: `WDT_RST_SEL, count: `WDT_RST_COUNT,
               prescale: 12'h000, ovfFlag: 1'b0, pinCnt: 4'h0, pinN: 1'b1,
               irqPulse: 1'b0, rstPulse: 1'b0, evtStat: 2'h0, evtEn: 2'h0,
               irqLevel: 1'b0, waitReq: 1'b1, rdata: 32'h00000000};
    end else begin
      stQ <= stD;
    end
  end

  // Outputs straight from the state register
  assign readdata = stQ.rdata;
  assign waitrequest = stQ.waitReq;
  assign overflowInterruptOut = stQ.irqPulse;
  assign sysResetReq = stQ.rstPulse;
  assign overflowPin_n = stQ.pinN;
  assign irq = stQ.irqLevel;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Overflow with reset enabled asks for a system reset next cycle
  a_reset_on_ovf: assert property (ovfEvent && stQ.reset_on_overflow |=> sysResetReq)
    else $error("reset request missing after overflow");

  // Interrupt pulse lasts exactly one cycle and follows an enabled overflow
  a_irq_single_pulse: assert property (overflowInterruptOut |-> $past(ovfEvent && stQ.interrupt_on_overflow) ##1 !overflowInterruptOut)
    else $error("interrupt pulse not a single cycle");

  // Pin stays low for eight cycles, then rises
  a_pin_pulse_len: assert property ($fell(overflowPin_n) |-> (!overflowPin_n) [*8] ##1 overflowPin_n)
    else $error("overflow pin pulse length wrong");

  // Counter steps down by one on an enabled tick
  a_count_step: assert property (tickNow && stQ.wdEn && !restartHit |=> stQ.count == $past(stQ.count) - 16'h0001)
    else $error("counter did not decrement");

  // Restart loads the preload value
  a_restart_load: assert property (restartHit |=> stQ.count == {$past(stQ.preHigh), 12'hfff})
    else $error("restart preload wrong");

  // Fastest divisor gives no tick in the eight cycles after one
  a_tick_spacing: assert property (tickNow && stQ.divSel == 2'h0 |=> !tickNow [*8])
    else $error("tick came too early");

  // Bad key leaves mode register unchanged
  a_mode_key: assert property (modeWrite && !modeKeyOk |=> $stable({stQ.pinEn, stQ.interrupt_on_overflow, stQ.reset_on_overflow, stQ.wdEn}))
    else $error("mode register changed without key");

  // Bad key leaves config register unchanged
  a_config_key: assert property (cfgWrite && !cfgKeyOk |=> $stable({stQ.preHigh, stQ.divSel}))
    else $error("config register changed without key");

  // Disabled watchdog drives no overflow output
  a_disabled_quiet: assert property (!stQ.wdEn && stQ.pinCnt == 4'h0 |=> !overflowInterruptOut && !sysResetReq && overflowPin_n)
    else $error("overflow output while disabled");

  // Overflow sets the status flag
  a_ovf_flag: assert property (ovfEvent |=> stQ.ovfFlag ##1 (stQ.ovfFlag || $past(restartHit)))
    else $error("overflow flag not set or lost");

  // A request seen while waiting is answered in the next cycle
  a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait cycle");

  // Completion lasts one cycle only, so an access is never taken twice
  a_wait_release: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Idle bus keeps waitrequest high
  a_idle_wait_high: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low without a request");

  // Mode key field always reads as zero
  a_mode_key_zero: assert property (read && waitrequest && address == `WDT_OFS_MODE |=> readdata[31:4] == 28'h0000000)
    else $error("mode key field not read as zero");

  // Config key field always reads as zero
  a_cfg_key_zero: assert property (read && waitrequest && address == `WDT_OFS_CONFIG |=> readdata[31:6] == 26'h0000000)
    else $error("config key field not read as zero");

  // Status read returns the overflow flag in bit 0
  a_status_read: assert property (read && waitrequest && address == `WDT_OFS_STATUS
    |=> readdata == {31'h00000000, $past(stQ.ovfFlag)})
    else $error("status read wrong");

  // Unmapped offset reads as zero
  a_unmapped_read: assert property (read && waitrequest && address == 5'h1c |=> readdata == 32'h00000000)
    else $error("unmapped read not zero");

  // Correct mode key loads all four control bits
  a_mode_write_ok: assert property (modeWrite && modeKeyOk
    |=> {stQ.pinEn, stQ.interrupt_on_overflow, stQ.reset_on_overflow, stQ.wdEn} == $past(writedata[3:0]))
    else $error("keyed mode write not taken");

  // Correct config key loads preload nibble and divider select
  a_cfg_write_ok: assert property (cfgWrite && cfgKeyOk |=> {stQ.preHigh, stQ.divSel} == $past(writedata[5:0]))
    else $error("keyed config write not taken");

  // Wrong restart value leaves the counter alone
  a_restart_ignored: assert property (restartBad && !(tickNow && stQ.wdEn) |=> $stable(stQ.count))
    else $error("wrong restart value moved the counter");

  // Restart without coincident overflow clears the flag
  a_restart_flag_clear: assert property (restartHit && !ovfEvent |=> !stQ.ovfFlag)
    else $error("restart did not clear overflow flag");

  // Flag stays set until a restart
  a_flag_sticky: assert property (stQ.ovfFlag && !restartHit |=> stQ.ovfFlag)
    else $error("overflow flag lost without restart");

  // Flag is only set by an overflow
  a_flag_set_only_ovf: assert property (!stQ.ovfFlag && !ovfEvent |=> !stQ.ovfFlag)
    else $error("overflow flag set without overflow");

  // Disabled counter holds its value
  a_count_hold_off: assert property (!stQ.wdEn && !restartHit |=> $stable(stQ.count))
    else $error("counter moved while disabled");

  // Counter moves only on a divided tick
  a_count_hold_notick: assert property (!tickNow && !restartHit |=> $stable(stQ.count))
    else $error("counter moved without a tick");

  // Overflow wraps the counter to all ones
  a_count_wrap: assert property (ovfEvent && !restartHit |=> stQ.count == 16'hffff)
    else $error("counter did not wrap on overflow");

  // Enabled overflow raises the interrupt pulse next cycle
  a_irq_follow: assert property (ovfEvent && stQ.interrupt_on_overflow |=> overflowInterruptOut)
    else $error("interrupt pulse missing after overflow");

  // No interrupt pulse without an enabled overflow
  a_irq_only_ovf: assert property (!(ovfEvent && stQ.interrupt_on_overflow) |=> !overflowInterruptOut)
    else $error("interrupt pulse without enabled overflow");

  // No reset request without an enabled overflow
  a_rst_only_ovf: assert property (!(ovfEvent && stQ.reset_on_overflow) |=> !sysResetReq)
    else $error("reset request without enabled overflow");

  // Reset request is a single cycle
  a_rst_single: assert property (sysResetReq |=> !sysResetReq)
    else $error("reset request longer than one cycle");

  // Enabled overflow pulls the pin low next cycle
  a_pin_start: assert property (ovfEvent && stQ.pinEn |=> !overflowPin_n)
    else $error("overflow pin did not fall");

  // Pin stays high while no pulse is running or starting
  a_pin_idle: assert property (stQ.pinCnt == 4'h0 && !(ovfEvent && stQ.pinEn) |=> overflowPin_n)
    else $error("overflow pin low without overflow");

  // Pulse counter never exceeds the pulse length
  a_pin_count_range: assert property (stQ.pinCnt <= `WDT_PIN_PULSE_CYCLES)
    else $error("pin pulse counter out of range");

  // Divide by 32 ticks on the last of each 32 prescaler states
  a_tick_sel0: assert property (tickNow && stQ.divSel == 2'h0 |-> stQ.prescale[4:0] == 5'h1f)
    else $error("divide by 32 tick misplaced");

  // Divide by 128 ticks on the last of each 128 prescaler states
  a_tick_sel1: assert property (tickNow && stQ.divSel == 2'h1 |-> stQ.prescale[6:0] == 7'h7f)
    else $error("divide by 128 tick misplaced");

  // Divide by 1024 ticks on the last of each 1024 prescaler states
  a_tick_sel2: assert property (tickNow && stQ.divSel == 2'h2 |-> stQ.prescale[9:0] == 10'h3ff)
    else $error("divide by 1024 tick misplaced");

  // Divide by 4096 ticks once per prescaler wrap
  a_tick_sel3: assert property (tickNow && stQ.divSel == 2'h3 |-> stQ.prescale == 12'hfff)
    else $error("divide by 4096 tick misplaced");

  // Prescaler runs free; restart does not disturb its phase
  a_prescale_run: assert property (1'b1 |=> stQ.prescale == $past(stQ.prescale) + 12'h001)
    else $error("prescaler did not advance");

  // Interrupt level follows enabled event bits
  a_irq_level: assert property (irq == |(stQ.evtStat & stQ.evtEn))
    else $error("interrupt level does not match events");

  // Event bit stays set until cleared
  a_evt_sticky: assert property (stQ.evtStat[0] && !evtClr[0] |=> stQ.evtStat[0])
    else $error("overflow event lost without clear");

  // An event in the clearing cycle survives the clear
  a_evt_set_wins: assert property (evtSet[0] && evtClr[0] |=> stQ.evtStat[0])
    else $error("clear won over a coincident event");

  // Rejected mode write is logged as an event
  a_badkey_event: assert property (modeWrite && !modeKeyOk |=> stQ.evtStat[1])
    else $error("rejected mode write not logged");

endmodule

// >>> dv/keyed_watchdog_timer_tb.sv
`timescale 1ns/1ps
module keyed_watchdog_timer_tb;
  // Bus driven by the bench
  logic clk;
  logic rst_b;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  // Observed outputs
  logic [31:0] readdata;
  logic waitrequest;
  logic ovfIrq;
  logic sysResetReq;
  logic overflowPin_n;
  logic irq;
  logic [31:0] rdVal;
  int errTotal = 0;
  int nTests = 0;
  int cyc = 0;
  int pinLow = 0;
  int pulseIrq = 0;
  int pulseRst = 0;
  int t;

  keyed_watchdog_timer DUT (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .overflowInterruptOut(ovfIrq), .sysResetReq(sysResetReq),
    .overflowPin_n(overflowPin_n), .irq(irq)
  );

  // Free running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counts overflow output cycles, so pulse widths are judged over the whole run
  always @(posedge clk) begin
    cyc++;
    if (rst_b && !overflowPin_n) pinLow++;
    if (rst_b && ovfIrq) pulseIrq++;
    if (rst_b && sysResetReq) pulseRst++;
    if (cyc == 32'h249f0) begin
      errTotal++;
      stopTest();
    end
  end

  task automatic stopTest();
    if (errTotal == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until the edge where waitrequest is seen low
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdVal = readdata;
    read <= 1'b0;
    chk(rdVal, exp);
  endtask

  // Main sequence; irq is registered, so two edges pass before it is judged
  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk({28'h0, overflowPin_n, ovfIrq, sysResetReq, irq}, 32'h8);
    for (int i = 0; i < 8; i++) if (i != 2 && i != 5) rchk(5'(i * 4), 32'h0);
    wr(5'h00, 32'h0000123f);
    rchk(5'h00, 32'h0);
    wr(5'h04, 32'h00003f17);
    rchk(5'h04, 32'h0);
    rchk(5'h10, 32'h2);
    wr(5'h18, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(5'h14, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // A wrong restart value is refused and logged as a rejected write
    wr(5'h08, 32'h0000c070);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(5'h18, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(5'h14, 32'h2);
    wr(5'h00, 32'h0000234e);
    rchk(5'h00, 32'he);
    wr(5'h04, 32'h00003716);
    rchk(5'h04, 32'h16);
    wr(5'h04, 32'h00003700);
    rchk(5'h04, 32'h0);
    rchk(5'h0c, 32'h0);
    chk(32'(pulseIrq + pulseRst + pinLow), 32'h0);
    // Arm: restart, then enable all actions; overflow on the 4096th tick of 32 clocks
    wr(5'h08, 32'h0000c071);
    wr(5'h00, 32'h0000234f);
    t = 0;
    while (sysResetReq !== 1'b1 && t < 32'h222e0) begin
      @(posedge clk);
      t++;
    end
    chk({31'h0, t >= 32'h1ffe0 && t <= 32'h20008}, 32'h1);
    repeat (12) @(posedge clk);
    chk(32'(pulseRst), 32'h1);
    chk(32'(pulseIrq), 32'h1);
    chk(32'(pinLow), 32'h8);
    rchk(5'h0c, 32'h1);
    rchk(5'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(5'h08, 32'h0000c071);
    rchk(5'h0c, 32'h0);
    // One restart after 2000 cycles, well inside the time-out, keeps the watchdog quiet
    repeat (2000) @(posedge clk);
    wr(5'h08, 32'h0000c071);
    rchk(5'h0c, 32'h0);
    chk(32'(pulseRst), 32'h1);
    stopTest();
  end
endmodule
